// ### hdl/ecnt_top.sv
// 24-bit event counter with wrap toggle and i2c read-out
`timescale 1ns/10ps
`default_nettype none
module ecnt_top #(
  parameter logic [6:0] DEV_ADDR = ecnt_pkg::DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic count_input,
  input wire logic clear_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wrap_out,
  output logic [ecnt_pkg::CNT_W-1:0] count_value
);
  import ecnt_pkg::*;

  ecnt_state_t q, d;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic cnt_lvl;
  logic clr_n_lvl;
  logic scl_lvl;
  logic sda_lvl;
  logic cnt_rise;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic addr_hit;

  // pick one byte of the snapshot, index 0 is the most significant
  function automatic logic [BYTE_W-1:0] snap_byte(
    input logic [CNT_W-1:0] val,
    input logic [1:0] idx
  );
    logic [BYTE_W-1:0] b;
    case (idx)
      2'h0: b = val[23:16];
      2'h1: b = val[15:8];
      default: b = val[7:0];
    endcase
    return b;
  endfunction : snap_byte

  assign pin_raw[PIN_SDA] = sda_in;
  assign pin_raw[PIN_SCL] = scl_in;
  assign pin_raw[PIN_CNT] = count_input;
  assign pin_raw[PIN_CLR] = clear_n;

  // every pin is foreign to clk, so each gets its own filter
  generate
    for (genvar i = 0; i < PIN_N; i++)
    begin : g_pin
      ecnt_pin_filt #(
        .RST_LVL(PIN_RST[i])
      ) u_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(pin_raw[i]),
        .level(pin_lvl[i])
      );
    end
  endgenerate

  assign sda_lvl = pin_lvl[PIN_SDA];
  assign scl_lvl = pin_lvl[PIN_SCL];
  assign cnt_lvl = pin_lvl[PIN_CNT];
  assign clr_n_lvl = pin_lvl[PIN_CLR];

  // edge and bus-condition decode on filtered levels
  assign cnt_rise = cnt_lvl & ~q.cnt_prev;
  assign scl_rise = scl_lvl & ~q.scl_prev;
  assign scl_fall = ~scl_lvl & q.scl_prev;
  assign bus_start = scl_lvl & q.scl_prev & q.sda_prev & ~sda_lvl;
  assign bus_stop = scl_lvl & q.scl_prev & ~q.sda_prev & sda_lvl;
  // only a read addressed to us is answered; writes are not acked
  assign addr_hit = (q.shreg[7:1] == DEV_ADDR) && q.shreg[RW_BIT];

  // next-state logic for counter and bus engine
  always_comb
  begin
    d = q;
    d.cnt_prev = cnt_lvl;
    d.scl_prev = scl_lvl;
    d.sda_prev = sda_lvl;

    // clear dominates counting, independent of count input edges
    if (!clr_n_lvl)
    begin
      d.cnt = CNT_RST;
    end
    else if (cnt_rise)
    begin
      // counting resumes once clear reads high
      d.cnt = q.cnt + 24'h000001;
      if (q.cnt == CNT_MAX)
      begin
        d.wrap = ~q.wrap;
      end
    end

    // start and stop win over any byte in flight
    if (bus_start)
    begin
      d.st = ECNT_ADDR;
      d.bitcnt = 3'h0;
      d.shreg = 8'h00;
      d.sda_pull = 1'b0;
    end
    else if (bus_stop)
    begin
      d.st = ECNT_IDLE;
      d.sda_pull = 1'b0;
    end
    else
    begin
      case (q.st)
        ECNT_IDLE:
        begin
          d.sda_pull = 1'b0;
        end
        ECNT_ADDR:
        begin
          // address bits are sampled while the clock is high
          if (scl_rise)
          begin
            d.shreg = {q.shreg[6:0], sda_lvl};
            d.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == LAST_BIT)
            begin
              d.st = ECNT_ACHK;
            end
          end
        end
        ECNT_ACHK:
        begin
          if (scl_fall)
          begin
            if (addr_hit)
            begin
              d.sda_pull = 1'b1;
              d.snap = q.cnt;
              d.st = ECNT_AACK;
            end
            else
            begin
              d.st = ECNT_IDLE;
            end
          end
        end
        ECNT_AACK:
        begin
          // end of ack slot: present msb of first byte
          if (scl_fall)
          begin
            d.bytecnt = 2'h0;
            d.bitcnt = 3'h0;
            d.shreg = snap_byte(q.snap, 2'h0);
            d.sda_pull = ~q.snap[23];
            d.st = ECNT_TX;
          end
        end
        ECNT_TX:
        begin
          // data changes only while the clock is low
          if (scl_fall)
          begin
            d.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == LAST_BIT)
            begin
              d.sda_pull = 1'b0;
              d.st = ECNT_TACK;
            end
            else
            begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_pull = ~q.shreg[6];
            end
          end
        end
        ECNT_TACK:
        begin
          // controller nack or third byte done ends the read
          if (scl_rise)
          begin
            if (sda_lvl || (q.bytecnt == LAST_BYTE))
            begin
              d.st = ECNT_IDLE;
            end
            else
            begin
              d.st = ECNT_TLOAD;
            end
          end
        end
        ECNT_TLOAD:
        begin
          if (scl_fall)
          begin
            d.bytecnt = q.bytecnt + 2'h1;
            d.bitcnt = 3'h0;
            d.shreg = snap_byte(q.snap, q.bytecnt + 2'h1);
            // a function result cannot be bit-selected, so use the loaded byte
            d.sda_pull = ~d.shreg[BYTE_W-1];
            d.st = ECNT_TX;
          end
        end
        default:
        begin
          d.st = ECNT_IDLE;
          d.sda_pull = 1'b0;
        end
      endcase
    end
  end

  // single state register; wrap and counter clear on reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q.cnt <= CNT_RST;
      q.wrap <= 1'b0;
      q.cnt_prev <= 1'b0;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.st <= ECNT_IDLE;
      q.bitcnt <= 3'h0;
      q.bytecnt <= 2'h0;
      q.shreg <= 8'h00;
      q.snap <= CNT_RST;
      q.sda_pull <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // open-drain data: low when enabled, never driven high
  assign sda_out = 1'b0;
  assign sda_oe = q.sda_pull;
  // the serial clock is input only, there is no clock driver here
  assign wrap_out = q.wrap;
  assign count_value = q.cnt;
endmodule : ecnt_top
`default_nettype wire

// ### common/ecnt_pkg.sv
// shared constants and state types for the i2c-read event counter
// Contract
// - 24-bit up-counter spanning 0 to 16,777,215
// - clear input low resets the counter
// - clear released high starts counting
// - each count input rising edge adds one
// - wrap output toggles on every max-to-zero rollover
// - wrap output low after power-on reset
// - controller reads count over two-wire bus
// - data bits move in step with controller clock
// - data line only pulled low or released
`default_nettype none
package ecnt_pkg;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam int BYTE_W = 8;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int RW_BIT = 0;
  // default bus address; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h3A;
  // filtered pin indices and their reset levels: bus lines high, count and clear_n low
  localparam int PIN_N = 4;
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_CNT = 2;
  localparam int PIN_CLR = 3;
  localparam logic [PIN_N-1:0] PIN_RST = 4'h3;

  typedef enum logic [2:0] {
    ECNT_IDLE = 3'b000,
    ECNT_ADDR = 3'b001,
    ECNT_ACHK = 3'b010,
    ECNT_AACK = 3'b011,
    ECNT_TX = 3'b100,
    ECNT_TACK = 3'b101,
    ECNT_TLOAD = 3'b110
  } ecnt_bus_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ecnt_filt_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic wrap;
    logic cnt_prev;
    logic scl_prev;
    logic sda_prev;
    ecnt_bus_st_t st;
    logic [2:0] bitcnt;
    logic [1:0] bytecnt;
    logic [BYTE_W-1:0] shreg;
    logic [CNT_W-1:0] snap;
    logic sda_pull;
  } ecnt_state_t;
endpackage : ecnt_pkg
`default_nettype wire

// ### hdl/ecnt_pin_filt.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module ecnt_pin_filt #(
  parameter logic RST_LVL = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level
);
  import ecnt_pkg::*;

  ecnt_filt_t q, d;

  // s1 feeds only s2; level follows once s2 and s3 agree
  always_comb
  begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3)
    begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '{s1: RST_LVL, s2: RST_LVL, s3: RST_LVL, lvl: RST_LVL};
    end
    else
    begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule : ecnt_pin_filt
`default_nettype wire

// ### sim/ecnt_i2c_ctl.sv
// two-wire bus controller model reading the count
`timescale 1ns/10ps
`default_nettype none
module ecnt_i2c_ctl (
  input wire logic clk,
  input wire logic sda_line,
  output var logic scl,
  output var logic sda_rel
);
  // idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one bit: data moves a cycle after the fall, sampled at the end of the high
  // low lasts six cycles: the device answers five cycles after a pin fall,
  // so a shorter low would let its data move while the clock is high
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk);
    sda_rel <= b;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    r = sda_line;
    scl <= 1'b0;
  endtask : bit_io
  // start, address with read bit, three bytes acked but the last, stop
  task automatic rd(input logic [6:0] adr, output logic [23:0] v, output logic ack);
    logic r;
    sda_rel <= 1'b0;
    repeat (4) @(posedge clk);
    scl <= 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(i == 0 ? 1'b1 : adr[i-1], r);
    bit_io(1'b1, r);
    ack = ~r;
    for (int i = 23; i >= 0; i--)
    begin
      bit_io(1'b1, v[i]);
      if (i % 8 == 0) bit_io(i == 0, r);
    end
    @(posedge clk);
    sda_rel <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda_rel <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : rd
endmodule : ecnt_i2c_ctl
`default_nettype wire

// ### sim/ecnt_top_chk.sv
// port assertions for the event counter
`timescale 1ns/10ps
`default_nettype none
module ecnt_top_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic count_input,
  input wire logic clear_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wrap_out,
  input wire logic [ecnt_pkg::CNT_W-1:0] count_value
);
  import ecnt_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // counter steps and their causes
  cnt_step_a: assert property ($changed(count_value) |-> count_value == CNT_RST ||
    count_value == $past(count_value) + 24'h000001) else $error("step");
  cnt_rise_a: assert property (count_value == $past(count_value) + 24'h000001 |->
    $past(count_input, 4)) else $error("no edge");
  cnt_edge_a: assert property (clear_n [*8] ##1 $rose(count_input) |->
    ##[3:7] $changed(count_value)) else $error("edge lost");
  clr_hold_a: assert property (!clear_n [*8] |-> count_value == CNT_RST)
    else $error("clear");
  // wrap only on rollover, idle out of reset
  wrap_tog_a: assert property ($changed(wrap_out) |->
    count_value == CNT_RST && $past(count_value) == CNT_MAX) else $error("wrap");
  rst_idle_a: assert property ($fell(sys_rst) |-> !wrap_out && count_value == CNT_RST)
    else $error("reset");
  // data line is open drain and moves only while the clock is low
  sda_od_a: assert property (sda_out == 1'b0)
    else $error("drive high");
  // the clock pin must be low both at the edge that moves data and the one before
  sda_move_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda move");
endmodule : ecnt_top_chk
bind ecnt_top ecnt_top_chk i_chk (.clk, .sys_rst, .count_input, .clear_n, .scl_in, .sda_in,
  .sda_out, .sda_oe, .wrap_out, .count_value);
`default_nettype wire

// ### sim/ecnt_top_tb.sv
// self-checking bench for the event counter
`timescale 1ns/10ps
`default_nettype none
module ecnt_top_tb;
  import ecnt_pkg::*;
  typedef struct packed {
    logic [15:0] edges;
    logic [CNT_W-1:0] cnt;
  } ecnt_row_t;
  ecnt_row_t rows [3] = '{'{16'h0000, 24'h000000}, '{16'h0001, 24'h000001},
    '{16'h012C, 24'h00012C}};
  logic clk, sys_rst, count_input, clear_n, scl, sda_rel, sda_out, sda_oe, wrap_out, ack;
  logic [CNT_W-1:0] count_value, v;
  int bad_count = 0, total_checks = 0, cycles = 0;
  // pulled-up data line: low when either side pulls
  wire logic sda_wire = sda_rel & (~sda_oe | sda_out);
  ecnt_top i_dut (.clk, .sys_rst, .count_input, .clear_n, .scl_in(scl), .sda_in(sda_wire),
    .sda_out, .sda_oe, .wrap_out, .count_value);
  ecnt_i2c_ctl i_ctl (.clk, .sda_line(sda_wire), .scl, .sda_rel);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // hang guard, far above the expected run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // count pulses 400 ns high in an 800 ns period, slow enough for the pin filter
  task automatic pulse(input logic [15:0] n);
    repeat (n)
    begin
      count_input <= 1'b1;
      repeat (4) @(posedge clk);
      count_input <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : pulse
  task automatic rd_chk(input logic [CNT_W-1:0] exp);
    i_ctl.rd(DEV_ADDR_DEF, v, ack);
    chk({23'h000000, ack}, 24'h000001);
    chk(v, exp);
  endtask : rd_chk
  initial
  begin
    sys_rst = 1'b1;
    count_input = 1'b0;
    clear_n = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({23'h000000, wrap_out}, 24'h000000);
    foreach (rows[i])
    begin
      clear_n <= 1'b0;
      repeat (8) @(posedge clk);
      clear_n <= 1'b1;
      repeat (8) @(posedge clk);
      pulse(rows[i].edges);
      chk(count_value, rows[i].cnt);
      rd_chk(rows[i].cnt);
      $display("row %0d done", i);
    end
    // edges under a held clear are ignored, counting resumes after
    clear_n <= 1'b0;
    pulse(16'h0003);
    chk(count_value, CNT_RST);
    clear_n <= 1'b1;
    repeat (8) @(posedge clk);
    pulse(16'h0002);
    chk(count_value, 24'h000002);
    $display("clear test done");
    // foreign address gets no ack and reads released ones
    i_ctl.rd(DEV_ADDR_DEF ^ 7'h01, v, ack);
    chk({23'h000000, ack}, 24'h000000);
    chk(v, CNT_MAX);
    $display("address test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(count_value, CNT_RST);
    chk({23'h000000, wrap_out}, 24'h000000);
    $display("reset test done");
    stop_test();
  end
endmodule : ecnt_top_tb
`default_nettype wire
